// [oqcfg_regs.sv]
// Purpose: o-qpsk configuration and transmit header register bank
// Assumes: control port and demodulator logic share clk_i
// Notes:   all outputs registered, settings lag a write by two cycles
//
// How it works
// - shaping select: raised or root raised cosine
// - chip rate code picks 100..2000 kchip/s
// - mr override enable, resets set
// - legacy override enable, resets set
// - legacy preamble threshold bits 5:3, reset 3
// - mr preamble threshold bits 2:0, reset 3
// - spur compensation bit enables compensation
// - reduced power only while listening mr only
// - proprietary rate modes accepted only when enabled
// - legacy checksum 32 bit at 0, 16 at 1
// - listen select: mr, legacy, both, none
// - high rate bit switches legacy rate
// - sfd search set picks searched sfd words
// - ppdu type: variable or fixed 7/18 octets
// - reserved bit zero value sent in header
// - mode 4 sets reserved bit one, 2000k only
// - phy type bit: mr or legacy transmit
// - header settings captured for next frame
// - override restarts search on sudden level jump
// - dual listen checksum by frame kind
`timescale 1ns/1ps
`default_nettype none
`include "oqcfg_consts.svh"

module oqcfg_regs (
   // clock and reset
   input  wire logic                     clk_i,
   input  wire logic                     resetn_i,
   // control port
   input  wire oqcfg_pkg::oqcfg_bus_req_t bus_i,
   output var  logic [7:0]               rdata_o,
   output var  logic                     rvalid_o,
   // receiver side
   input  wire oqcfg_pkg::oqcfg_rx_evt_t rx_i,
   output var  oqcfg_pkg::oqcfg_rx_ctl_t rx_ctl_o,
   output var  logic                     rx_restart_o,
   output var  logic                     rx_mode_reject_o,
   output var  logic                     rx_fcs_32_o,
   // transmitter side
   input  wire logic                     tx_frame_start_i,
   output var  oqcfg_pkg::oqcfg_tx_hdr_t tx_hdr_o
);

   // masked write: only assigned bits change, the rest stay zero
   function automatic logic [7:0] masked(input logic [7:0] d,
                                         input logic [7:0] m);
      masked = d & m;
   endfunction

   // true when a jump exceeds the limit for this frame kind
   function automatic logic jump_over(input logic [5:0] j,
                                      input logic       old);
      jump_over = old ? (j > `OQCFG_JUMP_OLD_DB)
                      : (j > `OQCFG_JUMP_MR_DB);
   endfunction

   // stored registers
   logic [7:0] chip_shape_reg;   // chip_shape_cfg
   logic [7:0] rx_ovr_pre_reg;   // rx_override_preamble_cfg
   logic [7:0] rx_mode_reg;      // rx_mode_cfg
   logic [7:0] sfd_rate_reg;     // sfd_rate_cfg
   logic [7:0] tx_header_reg;    // tx_header_cfg

   // write decode
   wire wr_c0 = bus_i.wr && (bus_i.addr == `OQCFG_IDX_CHIP_SHAPE);
   wire wr_c1 = bus_i.wr && (bus_i.addr == `OQCFG_IDX_RX_OVR_PRE);
   wire wr_c2 = bus_i.wr && (bus_i.addr == `OQCFG_IDX_RX_MODE);
   wire wr_c3 = bus_i.wr && (bus_i.addr == `OQCFG_IDX_SFD_RATE);
   wire wr_tx = bus_i.wr && (bus_i.addr == `OQCFG_IDX_TX_HEADER);

   // masked storage
   // writes keep only assigned bits; other indices are dropped
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         chip_shape_reg <= `OQCFG_RST_CHIP_SHAPE;
         rx_ovr_pre_reg <= `OQCFG_RST_RX_OVR_PRE;
         rx_mode_reg    <= `OQCFG_RST_RX_MODE;
         sfd_rate_reg   <= `OQCFG_RST_SFD_RATE;
         tx_header_reg  <= `OQCFG_RST_TX_HEADER;
      end else begin
         if (wr_c0) chip_shape_reg <= masked(bus_i.wdata,
                                             `OQCFG_MASK_CHIP_SHAPE);
         if (wr_c1) rx_ovr_pre_reg <= masked(bus_i.wdata,
                                             `OQCFG_MASK_RX_OVR_PRE);
         if (wr_c2) rx_mode_reg    <= masked(bus_i.wdata,
                                             `OQCFG_MASK_RX_MODE);
         if (wr_c3) sfd_rate_reg   <= masked(bus_i.wdata,
                                             `OQCFG_MASK_SFD_RATE);
         if (wr_tx) tx_header_reg  <= masked(bus_i.wdata,
                                             `OQCFG_MASK_TX_HEADER);
      end
   end

   // read mux, unmapped indices answer zero
   logic [7:0] rdata_next;
   assign rdata_next =
      (bus_i.addr == `OQCFG_IDX_CHIP_SHAPE) ? chip_shape_reg :
      (bus_i.addr == `OQCFG_IDX_RX_OVR_PRE) ? rx_ovr_pre_reg :
      (bus_i.addr == `OQCFG_IDX_RX_MODE)    ? rx_mode_reg    :
      (bus_i.addr == `OQCFG_IDX_SFD_RATE)   ? sfd_rate_reg   :
      (bus_i.addr == `OQCFG_IDX_TX_HEADER)  ? tx_header_reg  : 8'h00;

   // read data holds until the next read
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_o  <= 8'h00;
         rvalid_o <= 1'b0;
      end else begin
         rvalid_o <= bus_i.rd;
         if (bus_i.rd) rdata_o <= rdata_next;
      end
   end

   // field decode of the receive settings
   wire [1:0] listen_sel = rx_mode_reg[`OQCFG_F_LISTEN];
   wire [1:0] sfd_set    = sfd_rate_reg[`OQCFG_F_SFD_SET];
   wire [1:0] chip_rate  = chip_shape_reg[`OQCFG_F_CHIP];
   wire       old_csum16 = rx_mode_reg[`OQCFG_B_OLD_CSUM];
   wire       prop_ok    = rx_mode_reg[`OQCFG_B_PROP];

   oqcfg_pkg::oqcfg_rx_ctl_t rx_ctl_next;
   always_comb begin
      rx_ctl_next.shape_root_raised_cosine =
         chip_shape_reg[`OQCFG_B_SHAPE];
      rx_ctl_next.chip_rate_sel = chip_rate;
      rx_ctl_next.mr_rx_override_en = rx_ovr_pre_reg[`OQCFG_B_MR_OVR];
      rx_ctl_next.old_phy_override_en =
         rx_ovr_pre_reg[`OQCFG_B_OLD_OVR];
      rx_ctl_next.preamble_thresh_old = rx_ovr_pre_reg[`OQCFG_F_THR_OLD];
      rx_ctl_next.preamble_thresh_mr  = rx_ovr_pre_reg[`OQCFG_F_THR_MR];
      rx_ctl_next.spur_comp_en = rx_mode_reg[`OQCFG_B_SPUR];
      // reduced power gated by mr-only listening
      rx_ctl_next.reduced_power_rx = rx_mode_reg[`OQCFG_B_LOW_PWR] &&
                                     (listen_sel == `OQCFG_LISTEN_MR);
      rx_ctl_next.proprietary_rates_accept = prop_ok;
      // legacy checksum length, 0 selects 32 bit
      rx_ctl_next.old_phy_checksum_32 = !old_csum16;
      rx_ctl_next.listen_mr  = (listen_sel == `OQCFG_LISTEN_MR) ||
                               (listen_sel == `OQCFG_LISTEN_BOTH);
      rx_ctl_next.listen_old = (listen_sel == `OQCFG_LISTEN_OLD) ||
                               (listen_sel == `OQCFG_LISTEN_BOTH);
      rx_ctl_next.old_phy_high_rate = sfd_rate_reg[`OQCFG_B_HIGH_RATE];
      // sfd search: bit 0 adds sfd_2, bit 1 adds sfd_3
      rx_ctl_next.search_sfd2 = sfd_set[0];
      rx_ctl_next.search_sfd3 = sfd_set[1];
   end

   // settings are re-registered so outputs come from flip-flops
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) rx_ctl_o <= '0;
      else           rx_ctl_o <= rx_ctl_next;
   end

   // override restart
   // a sudden rise after the preamble means a stronger frame overlaps
   wire ovr_en = rx_i.old_phy ? rx_ovr_pre_reg[`OQCFG_B_OLD_OVR]
                              : rx_ovr_pre_reg[`OQCFG_B_MR_OVR];
   wire restart_next = rx_i.preamble_seen && ovr_en &&
                       jump_over(rx_i.jump_db, rx_i.old_phy);

   // reject proprietary modes when not accepted
   wire reject_next = rx_i.phr_valid && !rx_i.old_phy && !prop_ok &&
                      (rx_i.rate_mode > `OQCFG_MODE_STD_MAX);

   // checksum length from the frame's own kind
   wire fcs32_next = rx_i.old_phy ? !old_csum16 : rx_i.pc_fcs_32;

   // receive event outputs, restart and reject are one-cycle pulses
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rx_restart_o     <= 1'b0;
         rx_mode_reject_o <= 1'b0;
         rx_fcs_32_o      <= 1'b0;
      end else begin
         rx_restart_o     <= restart_next;
         rx_mode_reject_o <= reject_next;
         rx_fcs_32_o      <= fcs32_next;
      end
   end

   // transmit header build
   wire [2:0] tx_mode  = tx_header_reg[`OQCFG_F_RATE_MODE];
   wire       tx_type2 = tx_header_reg[`OQCFG_B_PPDU];
   // type 2 sends sfd_3 only when the set names sfd_1 and sfd_3
   wire       tx_sfd3  = tx_type2 && (sfd_set == `OQCFG_SFD_1_3);

   oqcfg_pkg::oqcfg_tx_hdr_t tx_hdr_next;
   always_comb begin
      tx_hdr_next.ppdu_type_tx = tx_type2;
      tx_hdr_next.sfd3_sel     = tx_sfd3;
      tx_hdr_next.fixed_len    = !tx_type2 ? `OQCFG_LEN_VAR  :
                                 tx_sfd3   ? `OQCFG_LEN_SFD3 :
                                             `OQCFG_LEN_SFD2;
      tx_hdr_next.reserved_bit_zero_tx = tx_header_reg[`OQCFG_B_RSV0];
      // mode 4 sets reserved bit one
      tx_hdr_next.reserved_bit_one = (tx_mode == `OQCFG_MODE_PROP);
      tx_hdr_next.rate_mode        = tx_mode;
      tx_hdr_next.mode_unsupported = (tx_mode == `OQCFG_MODE_PROP) &&
                                     (chip_rate != `OQCFG_CHIP_2000K);
      tx_hdr_next.phy_type_tx = tx_header_reg[`OQCFG_B_PHY_TYPE];
      tx_hdr_next.old_phy_high_rate = sfd_rate_reg[`OQCFG_B_HIGH_RATE];
   end

   // capture at frame start
   // holding the header steady keeps a mid-frame write from tearing it
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i)             tx_hdr_o <= '0;
      else if (tx_frame_start_i) tx_hdr_o <= tx_hdr_next;
   end

   // checks on the bank

   a_c1_reset_val: assert property (
      @(posedge clk_i) $rose(resetn_i) |->
         rx_ovr_pre_reg == `OQCFG_RST_RX_OVR_PRE)
      else $error("override/preamble reset value wrong");

   a_c2_masked_wr: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      wr_c2 |=> (rx_mode_reg == (($past(bus_i.wdata)) &
                                 `OQCFG_MASK_RX_MODE)))
      else $error("receive-mode write not masked");

   a_low_pwr_gate: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      rx_ctl_o.reduced_power_rx |->
         $past(listen_sel) == `OQCFG_LISTEN_MR)
      else $error("reduced power outside mr-only listening");

   a_thresh_follow: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      wr_c1 |-> ##2 rx_ctl_o.preamble_thresh_mr ==
                    $past(bus_i.wdata[`OQCFG_F_THR_MR], 2))
      else $error("mr threshold not passed on");

   a_restart_cause: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      rx_restart_o |-> $past(rx_i.preamble_seen) && $past(ovr_en))
      else $error("restart without preamble or override");

   a_restart_mr_lim: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      (rx_i.preamble_seen && !rx_i.old_phy &&
       rx_ovr_pre_reg[`OQCFG_B_MR_OVR] &&
       rx_i.jump_db == `OQCFG_JUMP_MR_DB + 6'h01) |=> rx_restart_o)
      else $error("mr jump over limit did not restart");

   a_no_restart_eq: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      (rx_i.old_phy && rx_i.jump_db == `OQCFG_JUMP_OLD_DB)
         |=> !rx_restart_o)
      else $error("legacy jump at limit restarted");

   a_prop_reject: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      rx_mode_reject_o |-> !$past(prop_ok) &&
         $past(rx_i.rate_mode) > `OQCFG_MODE_STD_MAX)
      else $error("reject while modes accepted");

   a_fcs_by_kind: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      $past(rx_i.old_phy) |-> rx_fcs_32_o == !$past(old_csum16))
      else $error("legacy checksum length not from its bit");

   a_tx_hold: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      !tx_frame_start_i |=> $stable(tx_hdr_o))
      else $error("tx header changed without frame start");

   a_rb1_mode4: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      tx_hdr_o.reserved_bit_one |-> tx_hdr_o.rate_mode ==
                                    `OQCFG_MODE_PROP)
      else $error("reserved bit one without mode 4");

   a_fixed_len: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      tx_hdr_o.ppdu_type_tx |-> tx_hdr_o.fixed_len ==
         (tx_hdr_o.sfd3_sel ? `OQCFG_LEN_SFD3 : `OQCFG_LEN_SFD2))
      else $error("type 2 length wrong");

   // header capture, receive decode and read path checks
   a_mode4_rb1: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      tx_hdr_o.rate_mode == `OQCFG_MODE_PROP |->
         tx_hdr_o.reserved_bit_one)
      else $error("mode 4 header without reserved bit one");

   a_mode4_unsup: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      tx_frame_start_i |=> tx_hdr_o.mode_unsupported ==
         ($past(tx_mode) == `OQCFG_MODE_PROP &&
          $past(chip_rate) != `OQCFG_CHIP_2000K))
      else $error("mode 4 support flag wrong");

   a_hdr_capture: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      tx_frame_start_i |=> tx_hdr_o.phy_type_tx ==
         $past(tx_header_reg[`OQCFG_B_PHY_TYPE]) &&
         tx_hdr_o.reserved_bit_zero_tx ==
         $past(tx_header_reg[`OQCFG_B_RSV0]))
      else $error("header not captured at frame start");

   a_reject_mr_only: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      rx_mode_reject_o |-> !$past(rx_i.old_phy) && $past(rx_i.phr_valid))
      else $error("reject outside an mr header");

   a_listen_none: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      $past(listen_sel) == `OQCFG_LISTEN_NONE |->
         !rx_ctl_o.listen_mr && !rx_ctl_o.listen_old)
      else $error("detection left on with listening disabled");

   a_read_answer: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      bus_i.rd |=> rvalid_o)
      else $error("read strobe without an answer");

   a_unmapped_zero: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      (bus_i.rd && bus_i.addr > `OQCFG_IDX_TX_HEADER) |=> rdata_o == 8'h00)
      else $error("unmapped index read not zero");

   a_spur_follow: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      rx_ctl_o.spur_comp_en == $past(rx_mode_reg[`OQCFG_B_SPUR]))
      else $error("spur compensation not passed on");

endmodule
`default_nettype wire

// [oqcfg_consts.svh]
// Purpose: named constants for the o-qpsk configuration register bank
// Assumes: included by bare name from the design files
// Notes:   definitions only, no logic
`ifndef OQCFG_CONSTS_SVH
`define OQCFG_CONSTS_SVH

// register indices on the control port
`define OQCFG_IDX_CHIP_SHAPE  3'h0
`define OQCFG_IDX_RX_OVR_PRE  3'h1
`define OQCFG_IDX_RX_MODE     3'h2
`define OQCFG_IDX_SFD_RATE    3'h3
`define OQCFG_IDX_TX_HEADER   3'h4

// writable bit masks, unassigned bits stay zero
`define OQCFG_MASK_CHIP_SHAPE 8'h0B
`define OQCFG_MASK_RX_OVR_PRE 8'hFF
`define OQCFG_MASK_RX_MODE    8'h3F
`define OQCFG_MASK_SFD_RATE   8'h2C
`define OQCFG_MASK_TX_HEADER  8'h3F

// reset values
`define OQCFG_RST_CHIP_SHAPE  8'h00
`define OQCFG_RST_RX_OVR_PRE  8'hDB
`define OQCFG_RST_RX_MODE     8'h0C
`define OQCFG_RST_SFD_RATE    8'h00
`define OQCFG_RST_TX_HEADER   8'h00

// field positions
`define OQCFG_B_SHAPE         3
`define OQCFG_F_CHIP          1:0
`define OQCFG_B_MR_OVR        7
`define OQCFG_B_OLD_OVR       6
`define OQCFG_F_THR_OLD       5:3
`define OQCFG_F_THR_MR        2:0
`define OQCFG_B_SPUR          5
`define OQCFG_B_LOW_PWR       4
`define OQCFG_B_PROP          3
`define OQCFG_B_OLD_CSUM      2
`define OQCFG_F_LISTEN        1:0
`define OQCFG_B_HIGH_RATE     5
`define OQCFG_F_SFD_SET       3:2
`define OQCFG_B_PPDU          5
`define OQCFG_B_RSV0          4
`define OQCFG_F_RATE_MODE     3:1
`define OQCFG_B_PHY_TYPE      0

// codes
`define OQCFG_LISTEN_MR       2'h0
`define OQCFG_LISTEN_OLD      2'h1
`define OQCFG_LISTEN_BOTH     2'h2
`define OQCFG_LISTEN_NONE     2'h3
`define OQCFG_SFD_1_3         2'h2
`define OQCFG_CHIP_2000K      2'h3
`define OQCFG_MODE_STD_MAX    3'h3
`define OQCFG_MODE_PROP       3'h4

// level jump limits in db and fixed psdu lengths in octets
`define OQCFG_JUMP_MR_DB      6'h0C
`define OQCFG_JUMP_OLD_DB     6'h09
`define OQCFG_LEN_SFD2        5'h07
`define OQCFG_LEN_SFD3        5'h12
`define OQCFG_LEN_VAR         5'h00

`endif

// [oqcfg_pkg.sv]
// Purpose: shared types of the o-qpsk configuration register bank
// Assumes: used by full scoped name, never imported
// Notes:   constants live in oqcfg_consts.svh
`default_nettype none
package oqcfg_pkg;

   // control port request
   typedef struct packed {
      logic       wr;     // write strobe, one cycle
      logic       rd;     // read strobe, one cycle
      logic [2:0] addr;   // register index
      logic [7:0] wdata;  // write data
   } oqcfg_bus_req_t;

   // events from the demodulator
   typedef struct packed {
      logic       preamble_seen; // preamble found, frame still open
      logic       old_phy;       // frame under way is legacy kind
      logic [5:0] jump_db;       // sudden level rise in db
      logic       phr_valid;     // header decoded, one cycle
      logic [2:0] rate_mode;     // decoded rate mode
      logic       pc_fcs_32;     // general checksum type, 1 = 32 bit
   } oqcfg_rx_evt_t;

   // receiver settings
   typedef struct packed {
      logic       shape_root_raised_cosine;
      logic [1:0] chip_rate_sel;
      logic       mr_rx_override_en;
      logic       old_phy_override_en;
      logic [2:0] preamble_thresh_old;
      logic [2:0] preamble_thresh_mr;
      logic       spur_comp_en;
      logic       reduced_power_rx;
      logic       proprietary_rates_accept;
      logic       old_phy_checksum_32;
      logic       listen_mr;
      logic       listen_old;
      logic       old_phy_high_rate;
      logic       search_sfd2;
      logic       search_sfd3;
   } oqcfg_rx_ctl_t;

   // header of the frame being sent
   typedef struct packed {
      logic       ppdu_type_tx;       // 1 = fixed length type
      logic       sfd3_sel;           // type 2 uses the third sfd
      logic [4:0] fixed_len;          // psdu octets, 0 = variable
      logic       reserved_bit_zero_tx;
      logic       reserved_bit_one;
      logic [2:0] rate_mode;
      logic       phy_type_tx;        // 1 = legacy
      logic       mode_unsupported;   // proprietary mode off 2000k
      logic       old_phy_high_rate;
   } oqcfg_tx_hdr_t;

endpackage
`default_nettype wire

// [tb_oqpsk_phy_config_regs.sv]
// Purpose: self-checking bench for the o-qpsk configuration register bank
// Assumes: one cycle read latency, settings lag a write by two cycles
// Notes:   read answers are checked from a queue by a separate monitor
`timescale 1ns/1ps
`default_nettype none
`include "oqcfg_consts.svh"

module tb_oqpsk_phy_config_regs;
   logic                      clk_i;            // 50 MHz clock
   logic                      resetn_i;         // async reset, low
   oqcfg_pkg::oqcfg_bus_req_t bus_i;            // control port request
   logic [7:0]                rdata_o;          // read data
   logic                      rvalid_o;         // read answer pulse
   oqcfg_pkg::oqcfg_rx_evt_t  rx_i;             // demodulator events
   oqcfg_pkg::oqcfg_rx_ctl_t  rx_ctl_o;         // receiver settings
   logic                      rx_restart_o;     // back to preamble search
   logic                      rx_mode_reject_o; // proprietary mode refused
   logic                      rx_fcs_32_o;      // checksum length select
   logic                      tx_frame_start_i; // header capture pulse
   oqcfg_pkg::oqcfg_tx_hdr_t  tx_hdr_o;         // captured header
   oqcfg_pkg::oqcfg_tx_hdr_t  hdr_exp;          // last expected header
   logic [7:0]                regm [0:7];       // register model
   logic [7:0]                rd_q [$];         // expected read answers
   integer                    n_mismatch;       // wrong results
   integer                    checks_done;      // comparisons made
   integer                    seed;             // random seed
   integer                    i;                // loop index
   logic [1:0]                kk;               // code under test
   logic [2:0]                ra;               // random index
   logic [7:0]                rw;               // random data

   oqcfg_regs dut_u (
      .clk_i            (clk_i),
      .resetn_i         (resetn_i),
      .bus_i            (bus_i),
      .rdata_o          (rdata_o),
      .rvalid_o         (rvalid_o),
      .rx_i             (rx_i),
      .rx_ctl_o         (rx_ctl_o),
      .rx_restart_o     (rx_restart_o),
      .rx_mode_reject_o (rx_mode_reject_o),
      .rx_fcs_32_o      (rx_fcs_32_o),
      .tx_frame_start_i (tx_frame_start_i),
      .tx_hdr_o         (tx_hdr_o)
   );

   // free running clock
   initial begin
      clk_i = 1'h0;
      forever #10 clk_i = ~clk_i;
   end

   // writable bits of each index, unmapped ones hold nothing
   function automatic logic [7:0] mask_of(input logic [2:0] a);
      case (a)
         `OQCFG_IDX_CHIP_SHAPE: mask_of = `OQCFG_MASK_CHIP_SHAPE;
         `OQCFG_IDX_RX_OVR_PRE: mask_of = `OQCFG_MASK_RX_OVR_PRE;
         `OQCFG_IDX_RX_MODE:    mask_of = `OQCFG_MASK_RX_MODE;
         `OQCFG_IDX_SFD_RATE:   mask_of = `OQCFG_MASK_SFD_RATE;
         `OQCFG_IDX_TX_HEADER:  mask_of = `OQCFG_MASK_TX_HEADER;
         default:               mask_of = 8'h00;
      endcase
   endfunction

   // receiver settings expected from the register model
   function automatic oqcfg_pkg::oqcfg_rx_ctl_t exp_ctl();
      oqcfg_pkg::oqcfg_rx_ctl_t e;
      e.shape_root_raised_cosine = regm[0][3];
      e.chip_rate_sel            = regm[0][1:0];
      e.mr_rx_override_en        = regm[1][7];
      e.old_phy_override_en      = regm[1][6];
      e.preamble_thresh_old      = regm[1][5:3];
      e.preamble_thresh_mr       = regm[1][2:0];
      e.spur_comp_en             = regm[2][5];
      e.reduced_power_rx         = regm[2][4] & (regm[2][1:0] == 2'h0);
      e.proprietary_rates_accept = regm[2][3];
      e.old_phy_checksum_32      = ~regm[2][2];
      e.listen_mr  = (regm[2][1:0] == 2'h0) | (regm[2][1:0] == 2'h2);
      e.listen_old = (regm[2][1:0] == 2'h1) | (regm[2][1:0] == 2'h2);
      e.old_phy_high_rate        = regm[3][5];
      e.search_sfd2              = regm[3][2];
      e.search_sfd3              = regm[3][3];
      return e;
   endfunction

   // one comparison, counted
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done = checks_done + 1;
      if (got !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // verdict and end of run
   task automatic end_sim;
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // single write cycle, model keeps only writable bits
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_i);
      bus_i <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
      @(posedge clk_i);
      bus_i <= '0;
      regm[a] = d & mask_of(a);
   endtask

   // single read cycle, expectation noted for the monitor
   task automatic rd(input logic [2:0] a);
      @(posedge clk_i);
      bus_i <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
      @(posedge clk_i);
      bus_i <= '0;
      rd_q.push_back(regm[a]);
   endtask

   task automatic settle;
      repeat (3) @(posedge clk_i);
   endtask

   // one demodulator event cycle, then the registered answers
   task automatic rx_ev(input logic o, input logic [5:0] j,
                        input logic [2:0] m, input logic pc,
                        input logic er, input logic ej, input logic ef);
      @(posedge clk_i);
      rx_i <= '{preamble_seen: 1'h1, old_phy: o, jump_db: j,
                phr_valid: 1'h1, rate_mode: m, pc_fcs_32: pc};
      @(posedge clk_i);
      rx_i <= '0;
      @(posedge clk_i);
      chk(32'({rx_restart_o, rx_mode_reject_o, rx_fcs_32_o}),
          32'({er, ej, ef}));
   endtask

   // header settings only reach the frame at the next start pulse
   task automatic tx_case(input logic [1:0] c, input logic [1:0] s,
                          input logic h, input logic [7:0] t);
      wr(`OQCFG_IDX_CHIP_SHAPE, {6'h00, c});
      wr(`OQCFG_IDX_SFD_RATE, {2'h0, h, 1'h0, s, 2'h0});
      wr(`OQCFG_IDX_TX_HEADER, t);
      settle;
      chk(32'(tx_hdr_o), 32'(hdr_exp));
      @(posedge clk_i);
      tx_frame_start_i <= 1'h1;
      @(posedge clk_i);
      tx_frame_start_i <= 1'h0;
      @(posedge clk_i);
      hdr_exp.ppdu_type_tx         = regm[4][5];
      hdr_exp.sfd3_sel             = regm[4][5] & (s == 2'h2);
      hdr_exp.fixed_len            = !regm[4][5] ? 5'h00 :
                                     (s == 2'h2) ? 5'h12 : 5'h07;
      hdr_exp.reserved_bit_zero_tx = regm[4][4];
      hdr_exp.rate_mode            = regm[4][3:1];
      hdr_exp.reserved_bit_one     = (regm[4][3:1] == 3'h4);
      hdr_exp.phy_type_tx          = regm[4][0];
      hdr_exp.mode_unsupported     = (regm[4][3:1] == 3'h4) & (c != 2'h3);
      hdr_exp.old_phy_high_rate    = h;
      chk(32'(tx_hdr_o), 32'(hdr_exp));
   endtask

   // monitor: each read answer takes the oldest expectation
   always @(posedge clk_i) begin
      if (rvalid_o === 1'h1) begin
         if (rd_q.size() == 0) chk(32'h1, 32'h0);
         else chk(32'(rdata_o), 32'(rd_q.pop_front()));
      end
   end

   // hang guard
   initial begin
      repeat (20000) @(posedge clk_i);
      chk(32'h1, 32'h0);
      end_sim;
   end

   // main sequence
   initial begin
      seed = 32'h3C9E06A4;
      n_mismatch = 0;
      checks_done = 0;
      resetn_i = 1'h0;
      bus_i = '0;
      rx_i = '0;
      tx_frame_start_i = 1'h0;
      hdr_exp = '0;
      for (i = 0; i < 8; i++) regm[i] = 8'h00;
      regm[1] = 8'hDB;
      regm[2] = 8'h0C;
      repeat (10) @(posedge clk_i);
      resetn_i <= 1'h1;
      settle;
      chk(32'(rx_ctl_o), 32'(exp_ctl()));
      for (i = 0; i < 8; i++) rd(i[2:0]);
      for (i = 0; i < 8; i++) begin
         wr(i[2:0], 8'hFF);
         rd(i[2:0]);
      end
      for (i = 0; i < 4; i++) begin
         kk = i[1:0];
         wr(`OQCFG_IDX_CHIP_SHAPE, {4'h0, kk[0], 1'h0, kk});
         wr(`OQCFG_IDX_RX_MODE, {2'h0, kk[1], 1'h1, ~kk[0], kk[0], kk});
         wr(`OQCFG_IDX_SFD_RATE, {2'h0, kk[0], 1'h0, kk, 2'h0});
         settle;
         chk(32'(rx_ctl_o), 32'(exp_ctl()));
      end
      repeat (24) begin
         ra = 3'($random(seed));
         rw = 8'($random(seed));
         wr(ra, rw);
         rd(ra);
      end
      settle;
      chk(32'(rx_ctl_o), 32'(exp_ctl()));
      wr(`OQCFG_IDX_RX_OVR_PRE, 8'hC0);
      wr(`OQCFG_IDX_RX_MODE, 8'h06);
      settle;
      rx_ev(1'h0, 6'h0C, 3'h0, 1'h1, 1'h0, 1'h0, 1'h1);
      rx_ev(1'h0, 6'h0D, 3'h3, 1'h0, 1'h1, 1'h0, 1'h0);
      rx_ev(1'h1, 6'h09, 3'h4, 1'h1, 1'h0, 1'h0, 1'h0);
      rx_ev(1'h1, 6'h0A, 3'h0, 1'h0, 1'h1, 1'h0, 1'h0);
      rx_ev(1'h0, 6'h00, 3'h4, 1'h1, 1'h0, 1'h1, 1'h1);
      wr(`OQCFG_IDX_RX_MODE, 8'h0A);
      settle;
      rx_ev(1'h0, 6'h00, 3'h4, 1'h0, 1'h0, 1'h0, 1'h0);
      rx_ev(1'h1, 6'h00, 3'h0, 1'h1, 1'h0, 1'h0, 1'h1);
      wr(`OQCFG_IDX_RX_OVR_PRE, 8'h80);
      settle;
      rx_ev(1'h1, 6'h14, 3'h0, 1'h0, 1'h0, 1'h0, 1'h1);
      wr(`OQCFG_IDX_RX_OVR_PRE, 8'h1B);
      settle;
      rx_ev(1'h0, 6'h3F, 3'h0, 1'h1, 1'h0, 1'h0, 1'h1);
      tx_case(2'h3, 2'h2, 1'h1, 8'h29);
      tx_case(2'h1, 2'h1, 1'h0, 8'h38);
      tx_case(2'h0, 2'h0, 1'h0, 8'h17);
      tx_case(2'h2, 2'h3, 1'h1, 8'hC6);
      // mid-run reset restores the reset settings and clears the header
      @(posedge clk_i);
      resetn_i <= 1'h0;
      repeat (2) @(posedge clk_i);
      resetn_i <= 1'h1;
      for (i = 0; i < 8; i++) regm[i] = 8'h00;
      regm[1] = 8'hDB;
      regm[2] = 8'h0C;
      hdr_exp = '0;
      settle;
      chk(32'(rx_ctl_o), 32'(exp_ctl()));
      chk(32'(tx_hdr_o), 32'(hdr_exp));
      rd(`OQCFG_IDX_RX_OVR_PRE);
      rd(`OQCFG_IDX_RX_MODE);
      settle;
      chk(32'(rd_q.size()), 32'h0);
      end_sim;
   end
endmodule
`default_nettype wire
